/* File: phy_power_control_register_bench.sv */
// Self-checking bench for the power control register block
`timescale 1ns/1ps
`default_nettype none
`include "ppcr_consts.svh"

module phy_power_control_register_bench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        core_clk;
    logic        reset_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    wire logic   hready;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        energy_detect;
    logic        clocks_off;
    logic        core_active;
    logic        energy_detect_on;
    logic        nlp_pulse;
    logic        scrambler_bypass;
    logic [3:0]  loopback_depth;
    logic        rx_nib_valid;
    logic [3:0]  rx_nib;
    logic        tx_nib_strobe;
    logic        tx_nib_valid;
    logic [3:0]  tx_nib;
    int          n_mismatch;
    int          num_checks;
    int          cyc;
    int          n;
    logic [31:0] rd;
    // Short pulse period keeps the sleep test brief
    localparam int unsigned NLP = 20;
    localparam logic [31:0] CTRL = {20'h0, `PPCR_CTRL_ADDR};
    localparam logic [31:0] STAT = {20'h0, `PPCR_STAT_ADDR};
    // One row: written word, word read back, {clk off, active, detect
    // on, bypass, depth}
    typedef struct packed {
        logic [31:0] wd;
        logic [31:0] rd;
        logic [7:0]  outs;
    } ppcr_row_s;
    ppcr_row_s rows [8];
    assign hready = hreadyout;

    ppcr_top #(.NLP_CYCLES(NLP)) uut (
        .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .energy_detect(energy_detect), .clocks_off(clocks_off),
        .core_active(core_active), .energy_detect_on(energy_detect_on),
        .nlp_pulse(nlp_pulse), .scrambler_bypass(scrambler_bypass),
        .loopback_depth(loopback_depth), .rx_nib_valid(rx_nib_valid),
        .rx_nib(rx_nib), .tx_nib_strobe(tx_nib_strobe),
        .tx_nib_valid(tx_nib_valid), .tx_nib(tx_nib)
    );
    // ------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb_cycle(input logic [31:0] a, input logic w,
                             input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
    // Outputs packed like the row field, sampled at the edge
    function automatic logic [31:0] outs_now();
        return {24'h0, clocks_off, core_active, energy_detect_on,
                scrambler_bypass, loopback_depth};
    endfunction
    task automatic pull(input logic v, input logic [3:0] nib);
        tx_nib_strobe <= 1'b1;
        @(posedge core_clk);
        tx_nib_strobe <= 1'b0;
        #1;
        chk_vec({31'h0, tx_nib_valid}, {31'h0, v});
        if (v) chk_vec({28'h0, tx_nib}, {28'h0, nib});
        @(posedge core_clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {hsel, hwrite, energy_detect, rx_nib_valid, tx_nib_strobe} = 5'h0;
        {haddr, hwdata} = 64'h0;
        {htrans, rx_nib} = 6'h0;
        hsize = 3'h2;
        {n_mismatch, num_checks, cyc} = '0;
        reset_n = 1'b0;
        rows[0] = '{32'h0000_0000, 32'h0000_0000, 8'h44};
        rows[1] = '{32'h0000_0C00, 32'h0000_0800, 8'h54};
        rows[2] = '{32'h0000_1100, 32'h0000_1100, 8'h45};
        rows[3] = '{32'h0000_5200, 32'h0000_5200, 8'h06};
        rows[4] = '{32'h0000_D300, 32'h0000_D300, 8'h88};
        rows[5] = '{32'h0000_6100, 32'h0000_6100, 8'h25};
        rows[6] = '{32'h0000_7100, 32'h0000_7100, 8'h25};
        rows[7] = '{32'hFFFF_04FF, 32'h0000_0000, 8'h44};
        repeat (16) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        chk_vec(outs_now(), 32'h0000_0045);
        chk_vec({30'h0, hreadyout, hresp}, 32'h0000_0002);
        ahb_cycle(CTRL, 1'b0, 32'h0);
        chk_vec(rd, 32'h0000_0100);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            ahb_cycle(CTRL, 1'b1, rows[i].wd);
            ahb_cycle(CTRL, 1'b0, 32'h0);
            chk_vec(rd, rows[i].rd);
            chk_vec(outs_now(), {24'h0, rows[i].outs});
        end
        $display("test table done");
        ahb_cycle(CTRL, 1'b1, 32'h0000_6A00);
        ahb_cycle(STAT, 1'b1, 32'hFFFF_FFFF);
        ahb_cycle(32'h0000_0000, 1'b0, 32'h0);
        chk_vec(rd, 32'h0);
        ahb_cycle(CTRL, 1'b0, 32'h0);
        chk_vec(rd, 32'h0000_6A00);
        ahb_cycle(CTRL, 1'b0, 32'h0);
        chk_vec(rd, 32'h0000_6A00);
        $display("test hold done");
        n = 0;
        while (nlp_pulse !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            n = n + 1;
        end
        @(posedge core_clk);
        n = 1;
        while (nlp_pulse !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            n = n + 1;
        end
        chk_vec(n, NLP);
        ahb_cycle(STAT, 1'b0, 32'h0);
        chk_vec(rd, 32'h0000_0001);
        ahb_cycle(CTRL, 1'b1, 32'h0000_7100);
        n = 0;
        repeat (3 * NLP) begin
            @(posedge core_clk);
            if (nlp_pulse !== 1'b0) n = n + 1;
        end
        chk_vec(n, 0);
        $display("test pulse done");
        energy_detect <= 1'b1;
        n = 0;
        while (core_active !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            n = n + 1;
        end
        chk_vec(outs_now(), 32'h0000_0045);
        energy_detect <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk_vec(outs_now(), 32'h0000_0045);
        ahb_cycle(CTRL, 1'b0, 32'h0);
        chk_vec(rd, 32'h0000_7100);
        ahb_cycle(STAT, 1'b0, 32'h0);
        chk_vec(rd, 32'h0000_0004);
        ahb_cycle(CTRL, 1'b1, 32'h0000_7100);
        ahb_cycle(CTRL, 1'b0, 32'h0);
        chk_vec(outs_now(), 32'h0000_0025);
        $display("test wake done");
        ahb_cycle(CTRL, 1'b1, 32'h0000_0100);
        for (int i = 0; i < 4; i++) begin
            rx_nib <= 4'hA + i[3:0];
            rx_nib_valid <= 1'b1;
            @(posedge core_clk);
        end
        rx_nib_valid <= 1'b0;
        @(posedge core_clk);
        pull(1'b0, 4'h0);
        rx_nib <= 4'hE;
        rx_nib_valid <= 1'b1;
        @(posedge core_clk);
        rx_nib_valid <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 5; i++) pull(1'b1, 4'hA + i[3:0]);
        pull(1'b0, 4'h0);
        $display("test loopback done");
        ahb_cycle(CTRL, 1'b1, 32'h0000_DB00);
        @(posedge core_clk);
        chk_vec(outs_now(), 32'h0000_0098);
        reset_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk_vec(outs_now(), 32'h0000_0045);
        reset_n <= 1'b1;
        @(posedge core_clk);
        ahb_cycle(CTRL, 1'b0, 32'h0);
        chk_vec(rd, 32'h0000_0100);
        $display("test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire

/* File: ppcr_consts.svh */
// Offsets, field positions, reset values and timing counts for the power control block
`ifndef PPCR_CONSTS_SVH
`define PPCR_CONSTS_SVH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define PPCR_CTRL_INDEX   8'h11
`define PPCR_STAT_INDEX   8'h14
`define PPCR_CTRL_ADDR    12'h044
`define PPCR_STAT_ADDR    12'h050
// ------------------------------------------------------------
// Control field positions
// ------------------------------------------------------------
`define PPCR_CLK_OFF_BIT  15
`define PPCR_PS_EN_BIT    14
`define PPCR_PS_SEL_HI    13
`define PPCR_PS_SEL_LO    12
`define PPCR_SCR_BYP_BIT  11
`define PPCR_RSVD_BIT     10
`define PPCR_DEPTH_HI     9
`define PPCR_DEPTH_LO     8
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PPCR_PS_SEL_RST   2'h0
`define PPCR_DEPTH_RST    2'h1
// ------------------------------------------------------------
// Power state codes and buffer depths
// ------------------------------------------------------------
`define PPCR_CODE_NORMAL  2'h0
`define PPCR_CODE_DOWN    2'h1
`define PPCR_CODE_ASLEEP  2'h2
`define PPCR_CODE_PSLEEP  2'h3
`define PPCR_DEPTH_C0     4'h4
`define PPCR_DEPTH_C1     4'h5
`define PPCR_DEPTH_C2     4'h6
`define PPCR_DEPTH_C3     4'h8
`define PPCR_FIFO_WORDS   4'h8
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define PPCR_NLP_PERIOD_MS 1400
`define PPCR_CLK_KHZ       200000
`define PPCR_NLP_CYCLES    (`PPCR_NLP_PERIOD_MS * `PPCR_CLK_KHZ)
`endif

/* File: ppcr_pkg.sv */
// Types shared by the power control block
`default_nettype none
package ppcr_pkg;
    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PPCR_NORMAL,
        PPCR_DOWN,
        PPCR_ACTIVE_SLEEP,
        PPCR_PASSIVE_SLEEP
    } ppcr_state_e;
endpackage
`default_nettype wire

/* File: ppcr_top.sv */
// Power control register bank with power state logic and loopback buffer
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ppcr_consts.svh"

// Contract
// - Bit 15 set turns the internal clock circuitry off; clear runs clocks.
// - Power state field resets to 00, meaning normal full operation.
// - Code 01 shuts all circuitry except the management serial port; here only core_active and energy_detect_on drop.
// - Code 10 keeps port and energy detect, sends link pulse every 1.4 s.
// - Code 11 sends no pulses; both sleeps wake when a partner appears.
// - Bit 11 set bypasses the scrambler; clear keeps it in path.
// - Bit 10 ignores writes and always reads zero.
// - Bits 9:8 select loopback depth 4, 5, 6 or 8 nibbles; reset 01.
// - Loopback buffer takes receive nibbles, gives them on transmit timing.
module ppcr_top #(
    parameter int unsigned NLP_CYCLES = `PPCR_NLP_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Line side
    input  wire logic        energy_detect,
    output logic             clocks_off,
    output logic             core_active,
    output logic             energy_detect_on,
    output logic             nlp_pulse,
    output logic             scrambler_bypass,
    output logic [3:0]       loopback_depth,
    // Loopback nibbles
    input  wire logic        rx_nib_valid,
    input  wire logic [3:0]  rx_nib,
    input  wire logic        tx_nib_strobe,
    output logic             tx_nib_valid,
    output logic [3:0]       tx_nib
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire        addr_take = hsel & hready & htrans[1];
    wire        hit_ctrl  = haddr[11:0] == `PPCR_CTRL_ADDR;
    wire        hit_stat  = haddr[11:0] == `PPCR_STAT_ADDR;
    wire        rd_take   = addr_take & ~hwrite;
    wire        wr_take   = addr_take & hwrite & hit_ctrl;

    logic        wr_ctrl_q;
    logic        rd_ctrl_q;
    logic [31:0] hrdata_q;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic       clk_off_q;
    logic       ps_en_q;
    logic [1:0] ps_sel_q;
    logic       scr_byp_q;
    logic [1:0] depth_q;

    wire        clk_off_d = wr_ctrl_q ? hwdata[`PPCR_CLK_OFF_BIT]
                                      : clk_off_q;
    wire        ps_en_d   = wr_ctrl_q ? hwdata[`PPCR_PS_EN_BIT]
                                      : ps_en_q;
    wire [1:0]  ps_sel_d  = wr_ctrl_q
                          ? hwdata[`PPCR_PS_SEL_HI:`PPCR_PS_SEL_LO]
                          : ps_sel_q;
    wire        scr_byp_d = wr_ctrl_q ? hwdata[`PPCR_SCR_BYP_BIT]
                                      : scr_byp_q;
    wire [1:0]  depth_d   = wr_ctrl_q
                          ? hwdata[`PPCR_DEPTH_HI:`PPCR_DEPTH_LO]
                          : depth_q;

    // Reserved bit 10 and the lower byte are never stored
    wire [15:0] ctrl_rd   = {clk_off_d, ps_en_d, ps_sel_d,
                             scr_byp_d, 1'b0, depth_d,
                             8'h00};

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_off_q <= 1'b0;
            ps_en_q   <= 1'b0;
            ps_sel_q  <= `PPCR_PS_SEL_RST;
            scr_byp_q <= 1'b0;
            depth_q   <= `PPCR_DEPTH_RST;
        end else begin
            clk_off_q <= clk_off_d;
            ps_en_q   <= ps_en_d;
            ps_sel_q  <= ps_sel_d;
            scr_byp_q <= scr_byp_d;
            depth_q   <= depth_d;
        end
    end

    // ------------------------------------------------------------
    // Energy detect synchroniser
    // ------------------------------------------------------------
    logic energy_meta_q;
    logic energy_sync_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            energy_meta_q <= 1'b0;
            energy_sync_q <= 1'b0;
        end else begin
            energy_meta_q <= energy_detect;
            energy_sync_q <= energy_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------
    ppcr_pkg::ppcr_state_e state_q;
    ppcr_pkg::ppcr_state_e state_d;
    logic                  woken_q;

    wire in_sleep = (state_q == ppcr_pkg::PPCR_ACTIVE_SLEEP) |
                    (state_q == ppcr_pkg::PPCR_PASSIVE_SLEEP);
    // Wake stays latched until software rewrites; a wake wins over it
    wire woken_d  = (in_sleep & energy_sync_q) |
                    (woken_q & ~wr_ctrl_q);

    always_comb begin
        state_d = ppcr_pkg::PPCR_NORMAL;
        if (ps_en_d & ~woken_d) begin
            case (ps_sel_d)
                `PPCR_CODE_NORMAL: state_d = ppcr_pkg::PPCR_NORMAL;
                `PPCR_CODE_DOWN:   state_d = ppcr_pkg::PPCR_DOWN;
                `PPCR_CODE_ASLEEP: state_d = ppcr_pkg::PPCR_ACTIVE_SLEEP;
                `PPCR_CODE_PSLEEP: state_d = ppcr_pkg::PPCR_PASSIVE_SLEEP;
                default:           state_d = ppcr_pkg::PPCR_NORMAL;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ppcr_pkg::PPCR_NORMAL;
            woken_q <= 1'b0;
        end else begin
            state_q <= state_d;
            woken_q <= woken_d;
        end
    end

    // Management port is never gated by any state
    assign core_active      = state_q == ppcr_pkg::PPCR_NORMAL;
    assign energy_detect_on = in_sleep;
    // Gating relies on software asking only in power-down
    assign clocks_off       = clk_off_q;
    assign scrambler_bypass = scr_byp_q;

    // ------------------------------------------------------------
    // Link pulse timer
    // ------------------------------------------------------------
    logic [31:0] nlp_cnt_q;
    logic        nlp_q;

    wire asleep_act = state_q == ppcr_pkg::PPCR_ACTIVE_SLEEP;
    wire nlp_wrap   = nlp_cnt_q == NLP_CYCLES - 1;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            nlp_cnt_q <= 32'h0000_0000;
            nlp_q     <= 1'b0;
        end else begin
            nlp_q     <= asleep_act & nlp_wrap;
            nlp_cnt_q <= (!asleep_act || nlp_wrap) ? 32'h0000_0000
                                                   : nlp_cnt_q + 32'h1;
        end
    end

    assign nlp_pulse = nlp_q;

    // ------------------------------------------------------------
    // Far-end loopback buffer
    // ------------------------------------------------------------
    logic [3:0] fifo_mem [8];
    logic [2:0] wptr_q;
    logic [2:0] rptr_q;
    logic [3:0] level_q;
    logic       draining_q;
    logic       tx_valid_q;
    logic [3:0] tx_nib_q;
    logic [3:0] depth_n;

    always_comb begin
        case (depth_q)
            2'h0:    depth_n = `PPCR_DEPTH_C0;
            2'h1:    depth_n = `PPCR_DEPTH_C1;
            2'h2:    depth_n = `PPCR_DEPTH_C2;
            default: depth_n = `PPCR_DEPTH_C3;
        endcase
    end
    assign loopback_depth = depth_n;

    // Prefill to the chosen depth so rate drift has slack both ways
    wire push       = rx_nib_valid & (level_q != `PPCR_FIFO_WORDS);
    wire pop        = tx_nib_strobe & draining_q & (level_q != 4'h0);
    wire drain_d    = (level_q == 4'h0) ? 1'b0
                    : (draining_q | (level_q >= depth_n));

    always_ff @(posedge core_clk) begin
        if (push) begin
            fifo_mem[wptr_q] <= rx_nib;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wptr_q     <= 3'h0;
            rptr_q     <= 3'h0;
            level_q    <= 4'h0;
            draining_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_nib_q   <= 4'h0;
        end else begin
            wptr_q     <= wptr_q + {2'h0, push};
            rptr_q     <= rptr_q + {2'h0, pop};
            level_q    <= level_q + {3'h0, push} - {3'h0, pop};
            draining_q <= drain_d;
            tx_valid_q <= pop;
            if (pop) begin
                tx_nib_q <= fifo_mem[rptr_q];
            end
        end
    end

    assign tx_nib_valid = tx_valid_q;
    assign tx_nib       = tx_nib_q;

    // ------------------------------------------------------------
    // Bus data phase
    // ------------------------------------------------------------
    // Reads see a write from the cycle before through the forward path
    wire [31:0] stat_rd = {24'h0, level_q, energy_sync_q, woken_q,
                           state_q == ppcr_pkg::PPCR_DOWN, in_sleep};
    wire [31:0] rd_mux  = hit_ctrl ? {16'h0, ctrl_rd}
                        : hit_stat ? stat_rd
                        : 32'h0000_0000;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ctrl_q <= 1'b0;
            rd_ctrl_q <= 1'b0;
            hrdata_q  <= 32'h0000_0000;
        end else begin
            wr_ctrl_q <= wr_take;
            rd_ctrl_q <= rd_take & hit_ctrl;
            hrdata_q  <= rd_take ? rd_mux : 32'h0000_0000;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_clk_off_write: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        wr_ctrl_q |=> clocks_off == $past(hwdata[15]))
        else $error("clock off bit not taken from write");

    a_normal_code: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (ps_sel_q == 2'h0 && !wr_ctrl_q) |=> core_active)
        else $error("code 00 not normal");

    a_down_state: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (ps_en_q && ps_sel_q == 2'h1 && !woken_q && !wr_ctrl_q)
        |=> !core_active && !energy_detect_on)
        else $error("power down leaves circuitry on");

    a_pulse_state: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        nlp_pulse |-> $past(state_q) == ppcr_pkg::PPCR_ACTIVE_SLEEP)
        else $error("link pulse outside active sleep");

    a_sleep_wake: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (in_sleep && energy_sync_q) |=> core_active)
        else $error("no wake on energy");

    a_scr_write: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        wr_ctrl_q |=> scrambler_bypass == $past(hwdata[11]))
        else $error("scrambler bypass not taken");

    a_rsvd_zero: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        rd_ctrl_q |-> hrdata[10] == 1'b0 && hrdata[7:0] == 8'h00)
        else $error("reserved bits read nonzero");

    a_depth_map: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (depth_q == 2'h3 |-> loopback_depth == 4'h8) and
        (depth_q == 2'h0 |-> loopback_depth == 4'h4))
        else $error("depth code mapped wrong");

    a_fifo_order: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        tx_nib_valid |-> $past(tx_nib_strobe) && $past(level_q) != 4'h0)
        else $error("nibble sent without strobe or data");

    a_ps_off: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (!ps_en_q && !wr_ctrl_q) |=> core_active)
        else $error("power save active while disabled");

    a_read_back: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        rd_ctrl_q |-> hrdata[15:8] == {clk_off_q, ps_en_q, ps_sel_q,
                                       scr_byp_q, 1'b0, depth_q})
        else $error("read back differs from stored value");
endmodule
`default_nettype wire
